/* File: src/cspes_config_shadow.v */
// Configuration shadow store with fault duty selection and incremental slew limiter.
//
// Behaviour
// RL1: All nonvolatile and shadow words are readable at any time, locked or not.
// RL2: Writes to nonvolatile and shadow words are dropped unless the device is unlocked.
// RL3: Words 0x18 to 0x1E have shadows at plus 0x40; 0x1F has none.
// RL4: An enable bit set lets its error drive the PWM; cleared, it is ignored.
// RL5: Fault duty applies only when output enable and signalling bits are both set.
// RL6: Bit 12, turns overflow, gives 72.5% duty.
// RL7: Bit 11, temperature range, gives 66.875% duty.
// RL8: Bit 10, field high, gives 61.25% duty.
// RL9: Bit 9, signal clipping, gives 55.625% duty.
// RL10: Bit 8, eeprom soft error, gives 50% duty.
// RL11: Bit 7, field low, gives 44.375% duty.
// RL12: Bit 6, undervoltage, gives 38.75% duty.
// RL13: Bit 5, averaging error, gives 33.125% duty.
// RL14: Bit 4, zero crossing error, gives 27.5% duty.
// RL15: Bit 3, lock loss, gives 21.875% duty.
// RL16: Bit 2, self test failure, gives 16.25% duty.
// RL17: Bit 1, eeprom uncorrectable error, gives 10.625% duty.
// RL18: Bit 0, oscillator frequency error, gives 5% duty.
// RL19: Slew field N spaces incremental edges by (N+1) x 125 ns; zero disables.
// RL20: Slew limiting caps velocity; system lowers resolution rather than slew.
// RL21: Controller unlocks by writing keys 00, 27, 81, 1F, 77 in order.
// RL22: With several enabled errors active, the highest bit position wins.
// RL23: Bits 31:26 of nonvolatile words hold check bits, used to correct on load.
`timescale 1ns/10ps
`include "cspes_defs.vh"

module cspes_config_shadow
(
   // Clock and reset.
   input  wire        hclk,
   input  wire        hresetn,
   // AHB-Lite slave.
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   // Error sources and incremental request, from other clock domains.
   input  wire [12:0] error_active,
   input  wire [2:0]  incr_state_req,
   // Fault duty outputs.
   output reg         pwm_fault_active,
   output reg  [12:0] pwm_fault_duty,
   // Slew-limited incremental outputs and lock flag.
   output reg  [2:0]  incr_state_out,
   output reg         unlocked_flag
);

   localparam integer SLEW_STEP_RAW =
      (`CSPES_SLEW_STEP_NS + `CSPES_CLK_PERIOD_NS - 1) / `CSPES_CLK_PERIOD_NS;
   // Rounded up, so a step is never shorter than the required spacing.
   localparam [`CSPES_SLEW_CNT_W-1:0] SLEW_STEP_CYC = SLEW_STEP_RAW[`CSPES_SLEW_CNT_W-1:0];

   // Key sequence states, one-hot.
   localparam [5:0] KS_IDLE = 6'h01;
   localparam [5:0] KS_K1   = 6'h02;
   localparam [5:0] KS_K2   = 6'h04;
   localparam [5:0] KS_K3   = 6'h08;
   localparam [5:0] KS_K4   = 6'h10;
   localparam [5:0] KS_OPEN = 6'h20;

   // Six check bits over 26 data bits, Hamming positions with overall parity.
   function [5:0] ecc_gen;
      input [25:0] d;
      integer i;
      integer p;
      reg [5:0] c;
      begin
         c = 6'h00;
         p = 3;
         for (i = 0; i < 26; i = i + 1)
         begin
            while (p == 4 || p == 8 || p == 16)
            begin
               p = p + 1;
            end
            if (d[i])
            begin
               c[4:0] = c[4:0] ^ p[4:0];
            end
            p = p + 1;
         end
         c[5] = ^{d, c[4:0]};
         ecc_gen = c;
      end
   endfunction

   // Corrects a single flipped data bit at an even-weight Hamming position; one at an odd-weight position is left as read.
   function [25:0] ecc_fix;
      input [31:0] w;
      integer i;
      integer p;
      reg [5:0] s;
      reg [25:0] d;
      begin
         d = w[`CSPES_DATA_MSB:0];
         s = ecc_gen(d) ^ w[`CSPES_ECC_MSB:`CSPES_ECC_LSB];
         p = 3;
         for (i = 0; i < 26; i = i + 1)
         begin
            while (p == 4 || p == 8 || p == 16)
            begin
               p = p + 1;
            end
            if (s[5] && s[4:0] == p[4:0])
            begin
               d[i] = ~d[i];
            end
            p = p + 1;
         end
         ecc_fix = d;
      end
   endfunction

   function is_nv;
      input [7:0] idx;
      begin
         is_nv = (idx >= `CSPES_NV_FIRST) && (idx <= `CSPES_NV_LAST);
      end
   endfunction

   // Shadow copies sit at the store index plus the shadow offset; the user word has none.
   function is_sh;
      input [7:0] idx;
      begin
         is_sh = (idx >= (`CSPES_NV_FIRST + `CSPES_SHADOW_OFS)) &&
                 (idx <= (`CSPES_SH_LAST + `CSPES_SHADOW_OFS));
      end
   endfunction

   reg  [31:0] nv_mem [0:7];
   reg  [25:0] sh_mem [0:6];
   reg  [5:0]  key_st_r;
   reg  [5:0]  key_st_nxt;
   reg         wr_pend_r;
   reg  [7:0]  wr_idx_r;
   reg  [2:0]  load_idx_r;
   reg         load_busy_r;
   reg  [12:0] err_s1_r;
   reg  [12:0] err_s2_r;
   reg  [12:0] err_s3_r;
   reg  [12:0] err_r;
   reg  [2:0]  inc_s1_r;
   reg  [2:0]  inc_s2_r;
   reg  [2:0]  inc_s3_r;
   reg  [2:0]  inc_r;
   reg  [`CSPES_SLEW_CNT_W-1:0] slew_cnt_r;
   reg  [12:0] duty_nxt;
   reg  [31:0] rd_nxt;
   integer     k;

   wire [7:0]  acc_idx  = haddr[9:2];
   wire        acc_go   = hsel && hready && htrans[1] == `CSPES_HTRANS_NONSEQ;
   wire [7:0]  wr_word  = wr_idx_r;
   wire [12:0] err_ena  = sh_mem[0][`CSPES_ERR_BITS-1:0];
   wire        flt_oe   = sh_mem[3][`CSPES_FAULT_OE_BIT];
   wire        flt_sig  = sh_mem[3][`CSPES_FAULT_SIG_BIT];
   wire        flt_gate = flt_oe && flt_sig;                          // [RL5]
   wire [5:0]  slew_n   = sh_mem[1][`CSPES_SLEW_MSB:`CSPES_SLEW_LSB];
   wire [12:0] err_hit  = err_r & err_ena;                            // [RL4]
   wire [7:0]  key_val  = hwdata[`CSPES_KEY_MSB:`CSPES_KEY_LSB];
   // Key writes are always taken; every other configuration write needs the open lock.
   wire        key_wr   = wr_pend_r && wr_word == `CSPES_IDX_KEY;
   wire        cfg_wr   = wr_pend_r && unlocked_flag;                 // [RL2]
   wire [`CSPES_SLEW_CNT_W-1:0] slew_need =
      (({4'h0, slew_n} + 10'h001) * SLEW_STEP_CYC) - 10'h001;

   // Zero wait states: writes land at the end of their data phase.
   assign hreadyout = 1'b1;
   assign hresp     = `CSPES_HRESP_OKAY;

   // Key sequence; a wrong code starts over, except in the open state where it is ignored; a correct first code restarts it.
   // Restarting from the open state relocks until the fifth code comes again.
   always @*
   begin
      key_st_nxt = key_st_r;
      if (key_wr)
      begin
         case (key_st_r)
            KS_IDLE: key_st_nxt = (key_val == `CSPES_KEY0) ? KS_K1 : KS_IDLE;
            KS_K1:   key_st_nxt = (key_val == `CSPES_KEY1) ? KS_K2 : KS_IDLE;
            KS_K2:   key_st_nxt = (key_val == `CSPES_KEY2) ? KS_K3 : KS_IDLE;
            KS_K3:   key_st_nxt = (key_val == `CSPES_KEY3) ? KS_K4 : KS_IDLE;
            KS_K4:   key_st_nxt = (key_val == `CSPES_KEY4) ? KS_OPEN : KS_IDLE;
            KS_OPEN: key_st_nxt = (key_val == `CSPES_KEY0) ? KS_K1 : KS_OPEN;
            default: key_st_nxt = KS_IDLE;
         endcase
      end
   end

   // Highest enabled active error picks the duty.
   always @*
   begin
      duty_nxt = `CSPES_DUTY_FULL;
      if (err_hit[12])                                                // [RL22]
         duty_nxt = `CSPES_DUTY_B12;                                  // [RL6]
      else if (err_hit[11])
         duty_nxt = `CSPES_DUTY_B11;                                  // [RL7]
      else if (err_hit[10])
         duty_nxt = `CSPES_DUTY_B10;                                  // [RL8]
      else if (err_hit[9])
         duty_nxt = `CSPES_DUTY_B9;                                   // [RL9]
      else if (err_hit[8])
         duty_nxt = `CSPES_DUTY_B8;                                   // [RL10]
      else if (err_hit[7])
         duty_nxt = `CSPES_DUTY_B7;                                   // [RL11]
      else if (err_hit[6])
         duty_nxt = `CSPES_DUTY_B6;                                   // [RL12]
      else if (err_hit[5])
         duty_nxt = `CSPES_DUTY_B5;                                   // [RL13]
      else if (err_hit[4])
         duty_nxt = `CSPES_DUTY_B4;                                   // [RL14]
      else if (err_hit[3])
         duty_nxt = `CSPES_DUTY_B3;                                   // [RL15]
      else if (err_hit[2])
         duty_nxt = `CSPES_DUTY_B2;                                   // [RL16]
      else if (err_hit[1])
         duty_nxt = `CSPES_DUTY_B1;                                   // [RL17]
      else if (err_hit[0])
         duty_nxt = `CSPES_DUTY_B0;                                   // [RL18]
   end

   // Reads are never gated by the lock state; unmapped indices read as zero, and the
   // user word has no shadow, so its shadow index falls through to zero too.
   always @*
   begin
      rd_nxt = `CSPES_ZERO32;
      if (is_nv(acc_idx))
         rd_nxt = nv_mem[acc_idx[2:0]];                               // [RL1]
      else if (is_sh(acc_idx))                                        // [RL3]
         rd_nxt = {6'h00, sh_mem[acc_idx[2:0]]};                      // [RL1]
      else if (acc_idx == `CSPES_IDX_KEY)
         rd_nxt = {31'h00000000, unlocked_flag};
      else if (acc_idx == `CSPES_IDX_ERR)
         rd_nxt = {19'h00000, err_r};
      else if (acc_idx == `CSPES_IDX_STAT)
         rd_nxt = {15'h0000, duty_nxt, 3'h0, pwm_fault_active};
   end

   // Bus pipeline, key state and synchronisers.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r     <= 1'b0;
         wr_idx_r      <= 8'h00;
         hrdata        <= 32'h00000000;
         key_st_r      <= KS_IDLE;
         unlocked_flag <= 1'b0;
         err_s1_r      <= 13'h0000;
         err_s2_r      <= 13'h0000;
         err_s3_r      <= 13'h0000;
         err_r         <= 13'h0000;
         inc_s1_r      <= 3'h0;
         inc_s2_r      <= 3'h0;
         inc_s3_r      <= 3'h0;
         inc_r         <= 3'h0;
      end
      else
      begin
         wr_pend_r     <= acc_go && hwrite;
         wr_idx_r      <= acc_idx;
         if (acc_go && !hwrite)
            hrdata <= rd_nxt;
         key_st_r      <= key_st_nxt;
         unlocked_flag <= key_st_nxt == KS_OPEN;
         err_s1_r      <= error_active;
         err_s2_r      <= err_s1_r;
         err_s3_r      <= err_s2_r;
         // A change counts once stages two and three agree, so a metastable sample is unused.
         for (k = 0; k < 13; k = k + 1)
         begin
            if (err_s2_r[k] == err_s3_r[k])
               err_r[k] <= err_s3_r[k];
         end
         inc_s1_r      <= incr_state_req;
         inc_s2_r      <= inc_s1_r;
         inc_s3_r      <= inc_s2_r;
         if (inc_s2_r == inc_s3_r)
            inc_r <= inc_s3_r;
      end
   end

   // Nonvolatile words with check bits and their shadow copies; after reset
   // the shadows reload from the store, correcting a single flipped bit at an even-weight data position.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         load_busy_r <= 1'b1;
         load_idx_r  <= 3'h0;
         // Shadow defaults stand until the load replaces them.
         sh_mem[0]   <= `CSPES_RST_ERR_ENA;
         sh_mem[1]   <= `CSPES_RST_INCR_CTL;
         sh_mem[2]   <= `CSPES_RST_ERR_MASK;
         sh_mem[3]   <= `CSPES_RST_PWM_CTL;
         sh_mem[4]   <= `CSPES_RST_ZERO;
         sh_mem[5]   <= `CSPES_RST_ZERO;
         sh_mem[6]   <= `CSPES_RST_ZERO;
      end
      else
      begin
         if (load_busy_r)
         begin
            // A blank word leaves the reset default in place, so an unprogrammed store
            // cannot wipe it; a word written as all zeros also reloads as the default.
            if (nv_mem[load_idx_r] != `CSPES_ZERO32)
               sh_mem[load_idx_r] <= ecc_fix(nv_mem[load_idx_r]);     // [RL23]
            load_idx_r  <= load_idx_r + 3'h1;
            load_busy_r <= load_idx_r != 3'h6;
         end
         else if (cfg_wr && is_sh(wr_word))                           // [RL3]
            sh_mem[wr_word[2:0]] <= hwdata[`CSPES_DATA_MSB:0];        // [RL2]
      end
   end

   // The store has no reset: it models nonvolatile content surviving power.
   always @(posedge hclk)
   begin
      if (cfg_wr && is_nv(wr_word))
         nv_mem[wr_word[2:0]] <=
            {ecc_gen(hwdata[`CSPES_DATA_MSB:0]), hwdata[`CSPES_DATA_MSB:0]}; // [RL23]
   end

   // Fault duty output is held in flip-flops.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pwm_fault_active <= 1'b0;
         pwm_fault_duty   <= `CSPES_DUTY_FULL;
      end
      else
      begin
         // Flag and duty move on one edge, so a reader never sees half a fault.
         pwm_fault_active <= flt_gate && (|err_hit);                  // [RL5]
         pwm_fault_duty   <= flt_gate ? duty_nxt : `CSPES_DUTY_FULL;  // [RL5]
      end
   end

   // Slew limiter: an output edge reloads the spacing counter; later changes
   // wait, then the output jumps to the latest input, so states passed meanwhile are skipped.
   // The counter is cleared while limiting is off, so a new setting starts clean.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         incr_state_out <= 3'h0;
         slew_cnt_r     <= {`CSPES_SLEW_CNT_W{1'b0}};
      end
      else if (slew_n == 6'h00)
      begin
         incr_state_out <= inc_r;                                     // [RL19]
         slew_cnt_r     <= {`CSPES_SLEW_CNT_W{1'b0}};
      end
      else if (slew_cnt_r != {`CSPES_SLEW_CNT_W{1'b0}})
         slew_cnt_r <= slew_cnt_r - 10'h001;                          // [RL19]
      else if (inc_r != incr_state_out)
      begin
         incr_state_out <= inc_r;
         slew_cnt_r     <= slew_need;                                 // [RL19]
      end
   end

endmodule

/* File: src/cspes_defs.vh */
// Constants of the configuration shadow, fault duty and slew limiter block.
`ifndef CSPES_DEFS_VH
`define CSPES_DEFS_VH

// Register word indices, byte address is four times the index.
`define CSPES_IDX_ERR_ENA      8'h18
`define CSPES_IDX_INCR_CTL     8'h19
`define CSPES_IDX_ERR_MASK     8'h1A
`define CSPES_IDX_PWM_CTL      8'h1B
`define CSPES_IDX_ROT_CFG      8'h1C
`define CSPES_IDX_LOW_PWR      8'h1D
`define CSPES_IDX_GEN_CFG      8'h1E
`define CSPES_IDX_USER         8'h1F
`define CSPES_SHADOW_OFS       8'h40
`define CSPES_IDX_KEY          8'h3C
`define CSPES_IDX_ERR          8'h3E
`define CSPES_IDX_STAT         8'h3F
`define CSPES_NV_FIRST         8'h18
`define CSPES_NV_LAST          8'h1F
`define CSPES_SH_LAST          8'h1E

// Unlock key sequence.
`define CSPES_KEY0             8'h00
`define CSPES_KEY1             8'h27
`define CSPES_KEY2             8'h81
`define CSPES_KEY3             8'h1F
`define CSPES_KEY4             8'h77
`define CSPES_KEY_MSB          15
`define CSPES_KEY_LSB          8

// Field positions.
`define CSPES_ECC_MSB          31
`define CSPES_ECC_LSB          26
`define CSPES_DATA_MSB         25
`define CSPES_ERR_BITS         13
`define CSPES_FAULT_OE_BIT     13
`define CSPES_FAULT_SIG_BIT    12
`define CSPES_SLEW_MSB         21
`define CSPES_SLEW_LSB         16

// Fault duty in per-mille times eight: 72.5% = 5800/8000 etc, exact.
`define CSPES_DUTY_W           13
`define CSPES_DUTY_FULL        13'h1F40
`define CSPES_DUTY_B12         13'h16A8
`define CSPES_DUTY_B11         13'h14E6
`define CSPES_DUTY_B10         13'h1324
`define CSPES_DUTY_B9          13'h1162
`define CSPES_DUTY_B8          13'h0FA0
`define CSPES_DUTY_B7          13'h0DDE
`define CSPES_DUTY_B6          13'h0C1C
`define CSPES_DUTY_B5          13'h0A5A
`define CSPES_DUTY_B4          13'h0898
`define CSPES_DUTY_B3          13'h06D6
`define CSPES_DUTY_B2          13'h0514
`define CSPES_DUTY_B1          13'h0352
`define CSPES_DUTY_B0          13'h0190

// Slew step time and clock period.
`define CSPES_SLEW_STEP_NS     125
`define CSPES_CLK_PERIOD_NS    20
`define CSPES_SLEW_CNT_W       10

// Reset values of the shadow words.
`define CSPES_RST_ERR_ENA      26'h0000000
`define CSPES_RST_INCR_CTL     26'h0081024
`define CSPES_RST_ERR_MASK     26'h0000000
`define CSPES_RST_PWM_CTL      26'h0670100
`define CSPES_RST_ZERO         26'h0000000

`define CSPES_HRESP_OKAY       1'b0
`define CSPES_HTRANS_NONSEQ    1'b1
`define CSPES_ZERO32           32'h00000000

`endif

/* File: test/cspes_config_shadow_tb.sv */
// Self-checking bench of the configuration shadow block.
`timescale 1ns/10ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("BAD %s exp %0h got %0h", n, e, a); end end

module cspes_config_shadow_tb;
   logic        hclk, hresetn, hsel, hwrite, clr, unl;
   logic [31:0] haddr, hwdata, r;
   logic [1:0]  htrans;
   logic [2:0]  hsize, incr_state_req;
   logic [12:0] error_active;
   wire         hreadyout, hresp, pwm_fault_active, unlocked_flag;
   wire  [31:0] hrdata;
   wire  [12:0] pwm_fault_duty;
   wire  [2:0]  incr_state_out;
   int          error_cnt, total_checks, seed, min_gap_ns, kstep, i;
   logic [31:0] mdl [0:255];
   logic [7:0]  codes [0:4] = '{8'h00, 8'h27, 8'h81, 8'h1F, 8'h77};
   logic [7:0]  ks [0:7] = '{8'h00, 8'h27, 8'h55, 8'h00, 8'h27, 8'h81, 8'h1F, 8'h77};

   cspes_config_shadow dut
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .error_active(error_active),
      .incr_state_req(incr_state_req), .pwm_fault_active(pwm_fault_active),
      .pwm_fault_duty(pwm_fault_duty), .incr_state_out(incr_state_out),
      .unlocked_flag(unlocked_flag)
   );

   cspes_ctrl_model u_ctrl
   (
      .hclk(hclk), .incr_state_out(incr_state_out), .clr(clr), .min_gap_ns(min_gap_ns)
   );

   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   function automatic bit mapped(input logic [7:0] x);
      return (x >= 8'h18 && x <= 8'h1F) || (x >= 8'h58 && x <= 8'h5E);
   endfunction

   task close_out;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task bus(input bit wr, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {22'h000000, idx, 2'b00};
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
      if (unl && mapped(idx))
         mdl[idx] = d;
   endtask

   task rd(input logic [7:0] idx);
      logic [31:0] q;
      bus(1'b0, idx, 32'h00000000, q);
      `CHK("word", mdl[idx][25:0], q[25:0])
   endtask

   task key(input logic [7:0] c);
      logic [31:0] q;
      bus(1'b1, 8'h3C, {16'h0000, c, 8'h00}, q);
      if (kstep == 5 && c == 8'h00)
         kstep = 1;
      else if (kstep < 5 && c == codes[kstep])
         kstep++;
      else if (kstep < 5)
         kstep = 0;
      unl = (kstep == 5);
      @(posedge hclk);
      `CHK("unlock", unl, unlocked_flag)
   endtask

   task fault(input logic [12:0] en, input logic [1:0] ctl, input logic [12:0] err);
      int          b;
      logic [12:0] ed;
      logic        ea;
      wr(8'h58, {19'h00000, en});
      wr(8'h5B, 32'h00670100 | {18'h00000, ctl, 12'h000});
      error_active <= err;
      repeat (10) @(posedge hclk);
      ea = 1'b0;
      ed = 13'h1F40;
      // Ascending scan so the highest enabled active bit is the one kept.
      for (b = 0; b < 13; b++)
         if (ctl == 2'b11 && en[b] && err[b])
         begin
            ea = 1'b1;
            ed = 13'h0190 + 13'h01C2 * b;
         end
      `CHK("fault", ea, pwm_fault_active)
      `CHK("duty", ed, pwm_fault_duty)
   endtask

   task slew(input int n);
      wr(8'h59, 32'h00001024 | (n << 16));
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      repeat (60)
      begin
         r = $random(seed);
         incr_state_req <= r[2:0];
         repeat (2) @(posedge hclk);
      end
      repeat (n * 21 + 30) @(posedge hclk);
      `CHK("incr", incr_state_req, incr_state_out)
      if (n == 0)
         `CHK("free", 1'b1, min_gap_ns < 125)
      else
         `CHK("gap", 1'b1, min_gap_ns >= (n + 1) * 125)
   endtask

   initial
   begin
      #400000;
      error_cnt++;
      close_out;
   end

   initial
   begin
      seed = 31;
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'b010;
      error_active = 13'h0000;
      incr_state_req = 3'b000;
      clr = 1'b1;
      unl = 1'b0;
      {error_cnt, total_checks, kstep} = '0;
      for (i = 0; i < 256; i++)
         mdl[i] = mapped(i[7:0]) ? 32'hXXXXXXXX : 32'h00000000;
      for (i = 8'h58; i <= 8'h5E; i++)
         mdl[i] = 32'h00000000;
      mdl[8'h59] = 32'h00081024;
      mdl[8'h5B] = 32'h00670100;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (8) @(posedge hclk);
      for (i = 8'h58; i <= 8'h5F; i++)
         wr(i[7:0], $random(seed));
      for (i = 8'h58; i <= 8'h5F; i++)
         rd(i[7:0]);
      $display("test locked done");
      for (i = 0; i < 8; i++)
         key(ks[i]);
      $display("test unlock done");
      for (i = 8'h18; i <= 8'h5F; i++)
         if (mapped(i[7:0]) || i == 8'h5F)
            wr(i[7:0], $random(seed));
      for (i = 8'h18; i <= 8'h5F; i++)
         if (mapped(i[7:0]) || i == 8'h5F)
            rd(i[7:0]);
      $display("test words done");
      for (i = 0; i < 13; i++)
      begin
         fault(13'h0001 << i, 2'b11, 13'h1FFF);
         fault(~(13'h0001 << i), 2'b11, 13'h0001 << i);
      end
      repeat (24)
      begin
         r = $random(seed);
         fault(r[12:0], r[14:13], r[27:15]);
      end
      error_active <= 13'h0000;
      $display("test fault done");
      slew(0);
      slew(2);
      slew(5);
      $display("test slew done");
      close_out;
   end
endmodule

bind cspes_config_shadow cspes_shadow_chk u_chk
(
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .error_active(error_active),
   .pwm_fault_active(pwm_fault_active), .pwm_fault_duty(pwm_fault_duty),
   .unlocked_flag(unlocked_flag)
);

/* File: test/cspes_ctrl_model.sv */
// Controller that reads the incremental outputs and logs edge spacing.
`timescale 1ns/10ps

module cspes_ctrl_model
(
   // Clock, watched outputs and clear.
   input wire       hclk,
   input wire [2:0] incr_state_out,
   input wire       clr,
   // Smallest spacing between output changes, in ns.
   output int       min_gap_ns
);
   longint     last_ns;
   logic [2:0] prev;

   // The spacing bounds the speed it can follow; resolution, not slew, is traded.
   always @(posedge hclk)
   begin
      if (clr)
      begin
         min_gap_ns <= 1000000;
         last_ns <= -1000000;
      end
      else if (incr_state_out !== prev)
      begin
         if ($time - last_ns < min_gap_ns)
            min_gap_ns <= int'($time - last_ns);
         last_ns <= $time;
      end
      prev <= incr_state_out;
   end
endmodule

/* File: test/cspes_shadow_chk_sva.sv */
// Port checker of the configuration shadow, fault duty and slew block.
`timescale 1ns/10ps

module cspes_shadow_chk
(
   // Clock and reset.
   input wire        hclk,
   input wire        hresetn,
   // Bus.
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire        hreadyout,
   input wire        hresp,
   input wire [31:0] hrdata,
   // Faults and lock.
   input wire [12:0] error_active,
   input wire        pwm_fault_active,
   input wire [12:0] pwm_fault_duty,
   input wire        unlocked_flag
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   wire take     = hsel & hready & htrans[1];
   wire rd_take  = take & !hwrite;
   wire key_take = take & hwrite & (haddr[9:2] == 8'h3C);
   reg  key_ph_r;

   // Marks the data phase of a key write, the only cycle the lock may move.
   always @(posedge hclk or negedge hresetn)
      if (!hresetn)
         key_ph_r <= 1'b0;
      else
         key_ph_r <= key_take;

   chk_bus_okay: assert property (hreadyout && hresp == 1'b0)
      else $error("bus answer not ready or not okay");
   chk_rdata_hold: assert property (!rd_take |=> $stable(hrdata))
      else $error("read data moved without a read");
   chk_shadow_gap: assert property (rd_take && haddr[9:2] == 8'h5F
      |=> hrdata == 32'h00000000)
      else $error("user word has a shadow copy");
   chk_unlock_code: assert property ($rose(unlocked_flag)
      |-> $past(key_ph_r) && $past(hwdata[15:8]) == 8'h77)
      else $error("unlock without final key");
   chk_unlock_keep: assert property (unlocked_flag && !key_ph_r |=> unlocked_flag)
      else $error("lock came back without key write");
   chk_idle_duty: assert property (!pwm_fault_active |-> pwm_fault_duty == 13'h1F40)
      else $error("duty altered without fault");
   chk_duty_legal: assert property (pwm_fault_active |-> pwm_fault_duty >= 13'h0190
      && pwm_fault_duty <= 13'h16A8 && (pwm_fault_duty - 13'h0190) % 13'h01C2 == 0)
      else $error("fault duty not a listed level");
   chk_err_quiet: assert property ((error_active == 13'h0000)[*8] |=> !pwm_fault_active)
      else $error("fault shown with no error");
endmodule
